// ---- logic/sesa_pkg.sv ----
// constants for the eeprom software access block
package sesa_pkg;
   localparam logic [11:0] ADDR_CMD_STATUS = 12'h260;
   localparam logic [11:0] ADDR_WORD_BUFFER = 12'h264;
   localparam logic [11:0] ADDR_HIGH_BYTE = 12'h26C;
   localparam int ADDR_FIELD_LO = 0;
   localparam int ADDR_FIELD_W = 13;
   localparam int CMD_FIELD_LO = 13;
   localparam int BUSY_BIT = 18;
   localparam int ADDR15_BIT = 20;
   localparam int WIDTH_FIELD_LO = 22;
   localparam logic [2:0] CMD_WRITE = 3'h2;
   localparam logic [2:0] CMD_READ = 3'h3;
   localparam logic [2:0] CMD_WREN = 3'h6;
   localparam logic [2:0] CMD_WRITE_LATCH_CLEAR_CMD = 3'h4;
   localparam logic [7:0] SIGNATURE = 8'h5A;
   localparam logic [1:0] WIDTH_NONE = 2'h0;
   localparam logic [1:0] WIDTH_MAX = 2'h3;
   localparam logic [2:0] WORD_BYTES = 3'h4;
   localparam logic [2:0] PROBE_BYTES = 3'h1;
   localparam int CLK_MHZ = 250;
   localparam int SCK_MAX_KHZ = 17860;
   // half period of the serial clock, rounded up so the rate stays under its maximum
   localparam int SCK_HALF_CYC = (CLK_MHZ * 1000 + 2 * SCK_MAX_KHZ - 1) / (2 * SCK_MAX_KHZ);
   localparam int SEL_GAP_NS = 100;
   localparam int SEL_GAP_CYC = (SEL_GAP_NS * CLK_MHZ + 999) / 1000;
   typedef enum logic [1:0] {ST_IDLE, ST_XFER, ST_GAP} sesa_state_e;
endpackage

// ---- logic/sesa_shift.sv ----
// one-byte serial shifter, mode 0, msb first
`timescale 1ns/10ps
module sesa_shift #(
   parameter int HALF_CYC = sesa_pkg::SCK_HALF_CYC
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic start,
   input wire logic [7:0] tx_byte,
   input wire logic miso,
   output logic done,
   output logic [7:0] rx_byte,
   output logic sck,
   output logic mosi
);
   logic active_r;
   logic [15:0] cnt_r;
   logic [2:0] bit_r;
   logic [7:0] tx_r;
   logic [7:0] rx_r;

   always_ff @(posedge clk)
   begin
      done <= 1'b0;
      if (srst)
      begin
         active_r <= 1'b0;
         cnt_r <= 16'h0000;
         bit_r <= 3'h0;
         tx_r <= 8'h00;
         rx_r <= 8'h00;
         rx_byte <= 8'h00;
         sck <= 1'b0;
         mosi <= 1'b0;
      end
      else if (start)
      begin
         active_r <= 1'b1;
         cnt_r <= 16'h0000;
         bit_r <= 3'h0;
         tx_r <= tx_byte;
         sck <= 1'b0;
         mosi <= tx_byte[7];
      end
      else if (active_r)
      begin
         if (cnt_r == 16'(HALF_CYC - 1))
         begin
            cnt_r <= 16'h0000;
            if (!sck)
            begin
               // rising edge: eeprom data sampled
               sck <= 1'b1;
               rx_r <= {rx_r[6:0], miso};
            end
            else
            begin
               sck <= 1'b0;
               if (bit_r == 3'h7)
               begin
                  active_r <= 1'b0;
                  done <= 1'b1;
                  rx_byte <= rx_r;
               end
               else
               begin
                  bit_r <= bit_r + 3'h1;
                  tx_r <= {tx_r[6:0], 1'b0};
                  mosi <= tx_r[6];
               end
            end
         end
         else
            cnt_r <= cnt_r + 16'h0001;
      end
   end
endmodule

// ---- logic/sesa_top.sv ----
// software random access path to an external serial eeprom
`timescale 1ns/10ps
module sesa_top #(
   parameter int HALF_CYC = sesa_pkg::SCK_HALF_CYC,
   parameter int GAP_CYC = sesa_pkg::SEL_GAP_CYC
) (
   input wire logic SYS_CLK,
   input wire logic SRST,
   input wire logic REG_WR,
   input wire logic REG_RD,
   input wire logic [11:0] REG_ADDR,
   input wire logic [31:0] REG_WDATA,
   output logic [31:0] REG_RDATA,
   output logic EE_SEL_N,
   output logic EE_SCK,
   output logic EE_MOSI,
   input wire logic EE_MISO
);
   sesa_pkg::sesa_state_e state_r;
   logic [2:0] cmd_r;
   logic [2:0] op_r;
   logic [12:0] addr_r;
   logic a15_r;
   logic [7:0] high_r;
   logic [31:0] buf_r;
   logic [1:0] width_r;
   logic probing_r;
   logic [1:0] probe_n_r;
   logic [1:0] nadr_r;
   logic [2:0] ndata_r;
   logic [3:0] idx_r;
   logic [7:0] gap_r;
   logic start_r;
   logic miso_m_r;
   logic miso_s_r;
   logic sh_done;
   logic [7:0] sh_rx;
   logic [7:0] tx_byte;
   logic [23:0] full_addr;
   logic [3:0] last_idx;
   logic [1:0] lane;
   logic busy;
   logic cmd_wr;
   logic cmd_go;
   logic [2:0] wcmd;
   logic [1:0] eff_width;

   function automatic logic cmd_known(input logic [2:0] c);
      cmd_known = (c == sesa_pkg::CMD_WRITE) || (c == sesa_pkg::CMD_READ) ||
                  (c == sesa_pkg::CMD_WREN) || (c == sesa_pkg::CMD_WRITE_LATCH_CLEAR_CMD);
   endfunction

   function automatic logic [2:0] data_bytes(input logic [2:0] c);
      data_bytes = ((c == sesa_pkg::CMD_WRITE) || (c == sesa_pkg::CMD_READ)) ? sesa_pkg::WORD_BYTES : 3'h0;
   endfunction

   assign busy = (state_r != sesa_pkg::ST_IDLE) || probing_r;
   assign cmd_wr = REG_WR && (REG_ADDR == sesa_pkg::ADDR_CMD_STATUS);
   assign wcmd = REG_WDATA[sesa_pkg::CMD_FIELD_LO +: 3];
   assign cmd_go = cmd_wr && !busy && cmd_known(wcmd);
   assign eff_width = (width_r == sesa_pkg::WIDTH_NONE) ? 2'h1 : width_r;
   assign full_addr = probing_r ? 24'h000000 : {high_r, a15_r, addr_r, 2'h0};
   assign last_idx = 4'(nadr_r) + 4'(ndata_r);
   assign lane = 2'(idx_r - 4'(nadr_r) - 4'h1);

   // opcode, then address msb first, then data low byte first
   always_comb
   begin
      tx_byte = 8'h00;
      if (idx_r == 4'h0)
         tx_byte = {5'h00, op_r};
      else if (idx_r <= 4'(nadr_r))
         tx_byte = full_addr[8 * (nadr_r - 2'(idx_r)) +: 8];
      else if (op_r == sesa_pkg::CMD_WRITE)
         tx_byte = buf_r[8 * lane +: 8];
   end

   always_ff @(posedge SYS_CLK)
   begin
      miso_m_r <= EE_MISO;
      miso_s_r <= miso_m_r;
   end

   sesa_shift #(.HALF_CYC(HALF_CYC)) u_shift (
      .clk(SYS_CLK),
      .srst(SRST),
      .start(start_r),
      .tx_byte(tx_byte),
      .miso(miso_s_r),
      .done(sh_done),
      .rx_byte(sh_rx),
      .sck(EE_SCK),
      .mosi(EE_MOSI)
   );

   // software-written fields
   always_ff @(posedge SYS_CLK)
   begin
      if (SRST)
      begin
         cmd_r <= 3'h0;
         addr_r <= 13'h0000;
         a15_r <= 1'b0;
         high_r <= 8'h00;
      end
      else if (REG_WR && !busy)
      begin
         if (REG_ADDR == sesa_pkg::ADDR_CMD_STATUS)
         begin
            cmd_r <= wcmd;
            addr_r <= REG_WDATA[sesa_pkg::ADDR_FIELD_LO +: sesa_pkg::ADDR_FIELD_W];
            a15_r <= REG_WDATA[sesa_pkg::ADDR15_BIT];
         end
         if (REG_ADDR == sesa_pkg::ADDR_HIGH_BYTE)
            high_r <= REG_WDATA[7:0];
      end
   end

   // sequencer: probe after reset, then software commands
   always_ff @(posedge SYS_CLK)
   begin
      start_r <= 1'b0;
      if (SRST)
      begin
         state_r <= sesa_pkg::ST_IDLE;
         op_r <= 3'h0;
         nadr_r <= 2'h1;
         ndata_r <= 3'h0;
         idx_r <= 4'h0;
         gap_r <= 8'h00;
         EE_SEL_N <= 1'b1;
         probing_r <= 1'b1;
         probe_n_r <= 2'h1;
         width_r <= sesa_pkg::WIDTH_NONE;
      end
      else
      begin
         case (state_r)
            sesa_pkg::ST_IDLE:
            begin
               if (probing_r || cmd_go)
               begin
                  state_r <= sesa_pkg::ST_XFER;
                  idx_r <= 4'h0;
                  start_r <= 1'b1;
                  EE_SEL_N <= 1'b0;
                  if (probing_r)
                  begin
                     op_r <= sesa_pkg::CMD_READ;
                     nadr_r <= probe_n_r;
                     ndata_r <= sesa_pkg::PROBE_BYTES;
                  end
                  else
                  begin
                     op_r <= wcmd;
                     nadr_r <= (data_bytes(wcmd) == 3'h0) ? 2'h0 : eff_width;
                     ndata_r <= data_bytes(wcmd);
                  end
               end
            end
            sesa_pkg::ST_XFER:
            begin
               if (sh_done)
               begin
                  if (idx_r == last_idx)
                  begin
                     state_r <= sesa_pkg::ST_GAP;
                     gap_r <= 8'(GAP_CYC);
                     EE_SEL_N <= 1'b1;
                  end
                  else
                  begin
                     idx_r <= idx_r + 4'h1;
                     start_r <= 1'b1;
                  end
               end
            end
            sesa_pkg::ST_GAP:
            begin
               if (gap_r == 8'h00)
               begin
                  state_r <= sesa_pkg::ST_IDLE;
                  if (probing_r)
                  begin
                     if (buf_r[7:0] == sesa_pkg::SIGNATURE)
                     begin
                        width_r <= probe_n_r;
                        probing_r <= 1'b0;
                     end
                     else if (probe_n_r == sesa_pkg::WIDTH_MAX)
                        probing_r <= 1'b0;
                     else
                        probe_n_r <= probe_n_r + 2'h1;
                  end
               end
               else
                  gap_r <= gap_r - 8'h01;
            end
            default:
               state_r <= sesa_pkg::ST_IDLE;
         endcase
      end
   end

   // word buffer: software loads, read data lands here
   always_ff @(posedge SYS_CLK)
   begin
      if (SRST)
         buf_r <= 32'h00000000;
      else if (state_r == sesa_pkg::ST_XFER && sh_done && op_r == sesa_pkg::CMD_READ && idx_r > 4'(nadr_r))
         buf_r[8 * lane +: 8] <= sh_rx;
      else if (REG_WR && !busy && REG_ADDR == sesa_pkg::ADDR_WORD_BUFFER)
         buf_r <= REG_WDATA;
   end

   always_ff @(posedge SYS_CLK)
   begin
      if (SRST)
         REG_RDATA <= 32'h00000000;
      else if (REG_RD)
      begin
         REG_RDATA <= 32'h00000000;
         case (REG_ADDR)
            sesa_pkg::ADDR_CMD_STATUS:
            begin
               REG_RDATA[sesa_pkg::ADDR_FIELD_LO +: sesa_pkg::ADDR_FIELD_W] <= addr_r;
               REG_RDATA[sesa_pkg::CMD_FIELD_LO +: 3] <= cmd_r;
               REG_RDATA[sesa_pkg::BUSY_BIT] <= busy;
               REG_RDATA[sesa_pkg::ADDR15_BIT] <= a15_r;
               REG_RDATA[sesa_pkg::WIDTH_FIELD_LO +: 2] <= width_r;
            end
            sesa_pkg::ADDR_WORD_BUFFER:
               REG_RDATA <= buf_r;
            sesa_pkg::ADDR_HIGH_BYTE:
               REG_RDATA[7:0] <= high_r;
            default:
               REG_RDATA <= 32'h00000000;
         endcase
      end
   end

   a_busy_on_cmd: assert property (@(posedge SYS_CLK) disable iff (SRST)
      cmd_go |=> busy [*3])
      else $error("busy not raised after command");
   a_busy_ignore: assert property (@(posedge SYS_CLK) disable iff (SRST)
      (cmd_wr && busy) |=> ($stable(addr_r) && $stable(cmd_r) && $stable(op_r)))
      else $error("command taken while busy");
   a_sel_frame: assert property (@(posedge SYS_CLK) disable iff (SRST)
      !EE_SEL_N |-> (state_r == sesa_pkg::ST_XFER))
      else $error("select low outside a frame");
   a_width_locked: assert property (@(posedge SYS_CLK) disable iff (SRST)
      !probing_r |=> ($stable(width_r) && !probing_r))
      else $error("width changed after detection");
   a_addr_bytes: assert property (@(posedge SYS_CLK) disable iff (SRST)
      cmd_go |=> (nadr_r == (($past(wcmd) inside {3'h2, 3'h3}) ? ((width_r == 2'h0) ? 2'h1 : width_r) : 2'h0)))
      else $error("address byte count wrong");
   a_word_size: assert property (@(posedge SYS_CLK) disable iff (SRST)
      (cmd_go && (wcmd == sesa_pkg::CMD_WRITE || wcmd == sesa_pkg::CMD_READ)) |=> (ndata_r == 3'h4))
      else $error("data transfer not four bytes");
   a_latch_cmds: assert property (@(posedge SYS_CLK) disable iff (SRST)
      (cmd_go && REG_WDATA == 32'h0000C000) |=> (op_r == 3'h6 && last_idx == 4'h0 && !EE_SEL_N))
      else $error("set write latch not issued");
   a_addr_layout: assert property (@(posedge SYS_CLK) disable iff (SRST)
      cmd_go |=> (addr_r == $past(REG_WDATA[12:0]) && a15_r == $past(REG_WDATA[20])))
      else $error("address fields not captured");
   a_read_lands: assert property (@(posedge SYS_CLK) disable iff (SRST)
      (sh_done && state_r == sesa_pkg::ST_XFER && op_r == 3'h3 && idx_r > 4'(nadr_r))
      |=> (buf_r[8 * $past(lane) +: 8] == $past(sh_rx)))
      else $error("read byte not stored");
   a_probe_width: assert property (@(posedge SYS_CLK) disable iff (SRST)
      (probing_r && state_r == sesa_pkg::ST_GAP && gap_r == 8'h00 && buf_r[7:0] == 8'h5A)
      |=> (width_r == $past(probe_n_r) && !probing_r))
      else $error("width not recorded from signature");
endmodule

// ---- testbench/sesa_eeprom_model.sv ----
// behavioural serial eeprom, blank at start, pull-up on its data output
`timescale 1ns/10ps
module sesa_eeprom_model #(
   parameter int ADDR_BYTES = 2
) (
   input wire logic sel_n,
   input wire logic sck,
   input wire logic mosi,
   output logic miso
);
   localparam int HD = 8 + 8 * ADDR_BYTES;
   logic [7:0] mem [0:2047];
   logic [7:0] sh = 8'h00;
   logic [7:0] op = 8'h00;
   logic [23:0] addr = 24'h0;
   logic [23:0] ra;
   logic wel = 1'b0;
   int nb = 0;
   initial
   begin
      miso = 1'b1;
      foreach (mem[i])
         mem[i] = 8'hFF;
   end
   always @(negedge sel_n)
   begin
      nb = 0;
      addr = 24'h0;
   end
   // released output floats up; a finished write drops the latch
   always @(posedge sel_n)
   begin
      miso = 1'b1;
      if (op == 8'h02)
         wel = 1'b0;
   end
   always @(posedge sck)
      if (!sel_n)
      begin
         sh = {sh[6:0], mosi};
         nb++;
         if (nb == 8)
            op = sh;
         if (nb == 8 && sh == 8'h06)
            wel = 1'b1;
         if (nb == 8 && sh == 8'h04)
            wel = 1'b0;
         if (nb > 8 && nb <= HD && nb % 8 == 0)
            addr = {addr[15:0], sh};
         if (nb > HD && nb % 8 == 0 && op == 8'h02 && wel)
         begin
            mem[{addr[16:15], addr[8:0]}] = sh;
            addr++;
         end
      end
   always @(negedge sck)
      if (!sel_n && op == 8'h03 && nb >= HD)
      begin
         ra = addr + 24'((nb - HD) / 8);
         miso = mem[{ra[16:15], ra[8:0]}][7 - (nb - HD) % 8];
      end
endmodule

// ---- testbench/tb_sesa_top.sv ----
// self-checking testbench for the eeprom software access path
`timescale 1ns/10ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin error_cnt++; \
   $display("mismatch t=%0t got %h exp %h", $time, g, e); end end
module tb_sesa_top;
   logic SYS_CLK = 1'b0;
   logic SRST = 1'b1;
   logic REG_WR = 1'b0;
   logic REG_RD = 1'b0;
   logic [11:0] REG_ADDR = 12'h0;
   logic [31:0] REG_WDATA = 32'h0;
   logic [31:0] REG_RDATA;
   logic EE_SEL_N;
   logic EE_SCK;
   logic EE_MOSI;
   logic EE_MISO;
   // second eeprom with three address bytes, chosen by use3
   logic miso2;
   logic miso3;
   logic use3 = 1'b0;
   int error_cnt = 0;
   int checked = 0;
   logic [63:0] rq[$];
   logic [15:0] fq[$];
   logic [63:0] e;
   logic [15:0] f;
   logic rd_q = 1'b0;
   logic [7:0] op_s = 8'h0;
   logic [7:0] fb;
   int nb = 0;
   logic [31:0] v;
   logic [31:0] w;
   logic [31:0] a;
   always #2 SYS_CLK = ~SYS_CLK;
   sesa_top #(.HALF_CYC(20), .GAP_CYC(2)) i_dut (.SYS_CLK(SYS_CLK), .SRST(SRST), .REG_WR(REG_WR),
      .REG_RD(REG_RD), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA),
      .EE_SEL_N(EE_SEL_N), .EE_SCK(EE_SCK), .EE_MOSI(EE_MOSI), .EE_MISO(EE_MISO));
   assign EE_MISO = use3 ? miso3 : miso2;
   sesa_eeprom_model #(.ADDR_BYTES(2)) i_mem (.sel_n(EE_SEL_N | use3), .sck(EE_SCK), .mosi(EE_MOSI),
      .miso(miso2));
   sesa_eeprom_model #(.ADDR_BYTES(3)) i_mem3 (.sel_n(EE_SEL_N | !use3), .sck(EE_SCK), .mosi(EE_MOSI),
      .miso(miso3));
   // read data watcher
   always @(posedge SYS_CLK)
      rd_q <= REG_RD;
   always @(negedge SYS_CLK)
      if (rd_q)
      begin
         e = rq.pop_front();
         if (e[63:32] != 32'h0)
            `CHK(REG_RDATA & e[63:32], e[31:0])
      end
   // frame watcher: opcode and clock count per select period
   always @(negedge EE_SEL_N)
      nb = 0;
   always @(posedge EE_SCK)
      if (!EE_SEL_N)
      begin
         if (nb < 8)
            op_s = {op_s[6:0], EE_MOSI};
         nb++;
      end
   always @(posedge EE_SEL_N)
      if (!SRST)
      begin
         f = (fq.size() > 0) ? fq.pop_front() : 16'hFFFF;
         `CHK({op_s, nb[7:0]}, f)
      end
   task automatic stop_test();
      $display("errors %0d checks %0d", error_cnt, checked);
      if (error_cnt == 0 && checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic wr(input logic [11:0] ad, input logic [31:0] d);
      @(negedge SYS_CLK);
      REG_ADDR = ad;
      REG_WDATA = d;
      REG_WR = 1'b1;
      @(negedge SYS_CLK);
      REG_WR = 1'b0;
   endtask
   task automatic rd(input logic [11:0] ad, input logic [31:0] m, input logic [31:0] x);
      @(negedge SYS_CLK);
      REG_ADDR = ad;
      REG_RD = 1'b1;
      rq.push_back({m, x});
      @(negedge SYS_CLK);
      REG_RD = 1'b0;
      v = REG_RDATA;
   endtask
   task automatic idle();
      for (int n = 0; n < 4000; n++)
      begin
         rd(12'h260, 32'h0, 32'h0);
         if (v[18] === 1'b0)
            return;
      end
      error_cnt++;
      stop_test();
   endtask
   task automatic cmd(input logic [31:0] d, input logic [15:0] fr);
      fq.push_back(fr);
      wr(12'h260, d);
      idle();
   endtask
   task automatic put(input logic [31:0] fld, input logic [31:0] d);
      wr(12'h264, d);
      cmd(32'h0000C000, {8'h06, 8'h08});
      fq.push_back({8'h02, fb});
      wr(12'h260, fld | 32'h00004000);
      rd(12'h260, 32'h00040000, 32'h00040000);
      wr(12'h264, ~d);
      wr(12'h260, 32'h00006000);
      idle();
   endtask
   task automatic get(input logic [31:0] fld, input logic [31:0] x);
      cmd(fld | 32'h00006000, {8'h03, fb});
      rd(12'h264, 32'hFFFFFFFF, x);
   endtask
   task automatic reset_dut(input int n);
      @(negedge SYS_CLK);
      SRST = 1'b1;
      repeat (12) @(negedge SYS_CLK);
      for (int i = 1; i <= n; i++)
         fq.push_back({8'h03, 8'(16 + 8 * i)});
      SRST = 1'b0;
      idle();
   endtask
   initial
   begin
      v = $urandom(8211);
      fb = 8'h30;
      reset_dut(3);
      rd(12'h260, 32'h00C40000, 32'h0);
      wr(12'h268, 32'hFFFFFFFF);
      rd(12'h268, 32'hFFFFFFFF, 32'h0);
      put(32'h0, 32'h00005A00);
      put(32'h0, 32'h00000001);
      cmd(32'h00008000, {8'h04, 8'h08});
      reset_dut(2);
      fb = 8'h38;
      rd(12'h260, 32'h00C00000, 32'h00800000);
      rd(12'h264, 32'h000000FF, 32'h0000005A);
      get(32'h0, 32'h0000005A);
      wr(12'h26C, 32'h000000A5);
      rd(12'h26C, 32'h000000FF, 32'h000000A5);
      for (int k = 0; k < 2; k++)
      begin
         a = 32'(1 + $urandom % 127);
         w = $urandom;
         put(a, w);
         put(a | 32'h00100000, ~w);
         get(a, w);
         get(a | 32'h00100000, ~w);
         put(a | 32'h00100000, {v[31:16], 16'hC3C3});
         get(a | 32'h00100000, {~w[31:16], 16'hC3C3});
      end
      use3 = 1'b1;
      reset_dut(3);
      fb = 8'h30;
      put(32'h0, 32'h005A0000);
      cmd(32'h00008000, {8'h04, 8'h08});
      reset_dut(3);
      rd(12'h260, 32'h00C00000, 32'h00C00000);
      fb = 8'h40;
      wr(12'h26C, 32'h00000001);
      put(a, w);
      get(a, w);
      wr(12'h26C, 32'h00000000);
      get(a, 32'hFFFFFFFF);
      @(negedge SYS_CLK);
      `CHK(fq.size(), 0)
      stop_test();
   end
endmodule
